/* include/cedc_params.svh */
`ifndef CEDC_PARAMS_SVH
`define CEDC_PARAMS_SVH
// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define CEDC_OFS_ECR    8'h00
`define CEDC_OFS_BSR    8'h04
`define CEDC_OFS_BCR    8'h08
`define CEDC_OFS_ALA    8'h0c
`define CEDC_OFS_ALB    8'h10
`define CEDC_OFS_TEST   8'h14
`define CEDC_OFS_PFCS   8'h18
`define CEDC_OFS_ROOT   8'h1c
// ---------------------------------------------
// field positions
// ---------------------------------------------
`define CEDC_ECR_DE     3
`define CEDC_ECR_PSE    4
`define CEDC_ECR_PAE    5
`define CEDC_ECR_MCE    6
`define CEDC_ECR_PGE    7
`define CEDC_BSR_RSV    12
`define CEDC_BCR_TYPE   16
`define CEDC_BP_NUM     4
// ---------------------------------------------
// writable masks, reset values, invalid codes and limits
// ---------------------------------------------
`define CEDC_ECR_MASK   32'h000000f8
`define CEDC_BSR_MASK   32'h0000e00f
`define CEDC_BCR_MASK   32'hffff27ff
`define CEDC_PFCS_MASK  32'h0000ffff
`define CEDC_ECR_RST    32'h00000000
`define CEDC_DESC_BAD0  8'h80
`define CEDC_DESC_BAD1  8'h00
`define CEDC_LEN_MAX    5'h0f
// ---------------------------------------------
// exception vectors
// ---------------------------------------------
`define CEDC_VEC_DE     8'h00
`define CEDC_VEC_UD     8'h06
`define CEDC_VEC_GP     8'h0d
`define CEDC_VEC_PF     8'h0e
`define CEDC_VEC_AC     8'h11
`define CEDC_VEC_MC     8'h12
`define CEDC_VEC_XF     8'h13
`endif

/* include/cedc_pkg.sv */
package cedc_pkg;
    // register select after alias resolution
    typedef enum logic [2:0] {
        SEL_NONE, SEL_ECR, SEL_BSR, SEL_BCR,
        SEL_PFCS, SEL_ROOT, SEL_BADOP
    } cedc_sel_t;

    // kind of access seen by breakpoints
    typedef enum logic [1:0] {
        ACC_EXEC, ACC_WRITE, ACC_READ, ACC_IO
    } cedc_acc_t;

    typedef struct packed {
        logic        v;
        logic        cur;
        logic [7:0]  vec;
    } cedc_flt_t;

    typedef struct packed {
        logic               valid;
        logic               prot_mode;
        logic               paging;
        logic               desc_load;
        logic [7:0]         acc_rights;
        logic               desc_accessed;
        logic               pte_walk;
        logic               pte_rsvd;
        logic               mem_ref;
        logic               misalign;
        logic               align_chk;
        logic               div_op;
        logic               div_word;
        logic               div_zero;
        logic signed [31:0] div_q;
        logic               lock_bad;
        logic [4:0]         insn_len;
        logic [5:0]         float_exc;
        logic               hw_err;
        logic               task_sw;
        logic               tss16;
        logic [31:0]        new_root;
        logic               acc_valid;
        cedc_acc_t          acc_kind;
    } cedc_evt_t;

    typedef struct packed {
        logic [31:0] ecr;
        logic [31:0] bsr;
        logic [31:0] bcr;
        logic [31:0] pfcs;
        logic [31:0] root;
        logic [31:0] rdata;
        cedc_flt_t   reg_flt;
        cedc_flt_t   flt;
        logic        addr_hi;
        logic        pg_4m;
        logic        pg_2m;
        logic        tlb_flush;
        logic        keep_glob;
        logic        desc_bad;
        logic        desc_rmw;
        logic [3:0]  bp_hit;
    } cedc_st_t;
endpackage

/* core/cedc_core.sv */
// Operation
// - extension flag with paging drives four extra lines, 36-bit addresses
// - keep-global flag spares global TLB entries on task switch or base write
// - large-page flag gives 4K/4M pages, or 4K/2M with extension
// - extension, global and large-page features only work in protected mode
// - descriptor access rights 80H or 00H are invalid
// - accessed-bit locked update only when the bit is still clear
// - status bit 12 ignores writes and reads zero
// - access type: 00 exec, 01 write, 10 io with extensions, 11 read/write
// - control bits 11, 12, 14, 15 always zero
// - extensions off: alias slots map to status and control
// - extensions on: alias slot access raises bad opcode
// - legacy test register access raises bad opcode
// - packed float error raises vector 19 and records conditions
// - hardware-error vector 18 only with check flag, clear at reset
// - writing one to a reserved special-register bit raises vector 13
// - reserved bit set in translation entry raises vector 14
// - unaligned reference with checking on raises vector 17
// - divide fault saves pointer to the divide itself
// - most negative quotient completes without divide fault
// - bad lock prefix use raises vector 6
// - instruction longer than 15 bytes raises vector 13
// - 16-bit task switch leaves the table root unchanged
// - extended control register resets to zero
`include "cedc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cedc_core (
    input  wire logic                clock_in,
    input  wire logic                reset_in,
    input  wire logic                ce_in,
    input  wire logic [7:0]          reg_addr_in,
    input  wire logic [31:0]         reg_wdata_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    input  wire cedc_pkg::cedc_evt_t evt_in,
    output logic [31:0]              reg_rdata_out,
    output cedc_pkg::cedc_flt_t      reg_flt_out,
    output cedc_pkg::cedc_flt_t      flt_out,
    output logic                     addr_hi_en_out,
    output logic                     pg_4m_out,
    output logic                     pg_2m_out,
    output logic                     tlb_flush_out,
    output logic                     tlb_keep_global_out,
    output logic                     desc_bad_out,
    output logic                     desc_rmw_out,
    output logic [3:0]               bp_hit_out,
    output logic [31:0]              root_out
);
    import cedc_pkg::*;

    cedc_st_t  st;
    cedc_st_t  next_st;
    cedc_sel_t sel;
    logic [3:0] hit;
    logic       ext_on;

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    // ---------------------------------------------
    // decode helpers
    // ---------------------------------------------
    // address to register, alias slots folded in
    function automatic cedc_sel_t dec(input logic [7:0] a, input logic de);
        cedc_sel_t s;
        s = SEL_NONE;
        case (a)
            `CEDC_OFS_ECR:  s = SEL_ECR;
            `CEDC_OFS_BSR:  s = SEL_BSR;
            `CEDC_OFS_BCR:  s = SEL_BCR;
            `CEDC_OFS_ALA:  s = de ? SEL_BADOP : SEL_BSR;
            `CEDC_OFS_ALB:  s = de ? SEL_BADOP : SEL_BCR;
            `CEDC_OFS_TEST: s = SEL_BADOP;
            `CEDC_OFS_PFCS: s = SEL_PFCS;
            `CEDC_OFS_ROOT: s = SEL_ROOT;
            default:        s = SEL_NONE;
        endcase
        return s;
    endfunction

    // fault record builder
    function automatic cedc_flt_t mk(input logic [7:0] v);
        cedc_flt_t f;
        f.v   = 1'b1;
        f.cur = 1'b1;
        f.vec = v;
        return f;
    endfunction

    // quotient out of range for its size
    function automatic logic div_ovf(input logic signed [31:0] q,
                                     input logic w);
        logic o;
        if (w) begin
            o = (q > 32'sh00007fff) || (q < 32'shffff8000);
        end else begin
            o = (q > 32'sh0000007f) || (q < 32'shffffff80);
        end
        return o;
    endfunction

    assign sel    = dec(reg_addr_in, st.ecr[`CEDC_ECR_DE]);
    assign ext_on = st.ecr[`CEDC_ECR_DE];

    // ---------------------------------------------
    // breakpoint type match
    // ---------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `CEDC_BP_NUM; gi++) begin : g_bp
            logic [1:0] ty;
            logic       en;
            logic       m;
            assign ty = st.bcr[`CEDC_BCR_TYPE + 4*gi +: 2];
            assign en = st.bcr[2*gi] | st.bcr[2*gi+1];
            // type decode per field
            always_comb begin
                case (ty)
                    2'h0: m = evt_in.acc_kind == ACC_EXEC;
                    2'h1: m = evt_in.acc_kind == ACC_WRITE;
                    2'h2: m = ext_on &&
                              evt_in.acc_kind == ACC_IO;
                    default: m = evt_in.acc_kind == ACC_WRITE ||
                                 evt_in.acc_kind == ACC_READ;
                endcase
            end
            assign hit[gi] = evt_in.valid & evt_in.acc_valid & en & m;
        end
    endgenerate

    // ---------------------------------------------
    // next state
    // ---------------------------------------------
    always_comb begin
        next_st           = st;
        next_st.rdata     = 32'h00000000;
        next_st.reg_flt   = '0;
        next_st.flt       = '0;
        next_st.tlb_flush = 1'b0;
        next_st.desc_bad  = 1'b0;
        next_st.desc_rmw  = 1'b0;
        next_st.bp_hit    = 4'h0;

        // mode outputs, gated by protected mode
        next_st.addr_hi = st.ecr[`CEDC_ECR_PAE] & evt_in.paging &
                          evt_in.prot_mode;
        next_st.pg_4m   = st.ecr[`CEDC_ECR_PSE] & evt_in.prot_mode &
                          ~st.ecr[`CEDC_ECR_PAE];
        next_st.pg_2m   = st.ecr[`CEDC_ECR_PSE] & evt_in.prot_mode &
                          st.ecr[`CEDC_ECR_PAE];
        next_st.keep_glob = st.ecr[`CEDC_ECR_PGE] &
                            evt_in.prot_mode;

        // register writes
        if (reg_wr_in) begin
            case (sel)
                SEL_ECR: begin
                    if ((reg_wdata_in & ~`CEDC_ECR_MASK) != 32'h0) begin
                        next_st.reg_flt = mk(`CEDC_VEC_GP);
                    end else begin
                        next_st.ecr = reg_wdata_in;
                    end
                end
                SEL_BSR: next_st.bsr = reg_wdata_in & `CEDC_BSR_MASK;
                SEL_BCR: next_st.bcr = reg_wdata_in & `CEDC_BCR_MASK;
                SEL_PFCS: begin
                    if ((reg_wdata_in & ~`CEDC_PFCS_MASK) != 32'h0) begin
                        next_st.reg_flt = mk(`CEDC_VEC_GP);
                    end else begin
                        next_st.pfcs = reg_wdata_in;
                    end
                end
                SEL_ROOT: begin
                    next_st.root      = reg_wdata_in;
                    next_st.tlb_flush = 1'b1;
                end
                SEL_BADOP: next_st.reg_flt = mk(`CEDC_VEC_UD);
                default: next_st.rdata = 32'h00000000;
            endcase
        end

        // register reads
        if (reg_rd_in) begin
            case (sel)
                SEL_ECR:   next_st.rdata = st.ecr;
                SEL_BSR:   next_st.rdata = st.bsr;
                SEL_BCR:   next_st.rdata = st.bcr;
                SEL_PFCS:  next_st.rdata = st.pfcs;
                SEL_ROOT:  next_st.rdata = st.root;
                SEL_BADOP: next_st.reg_flt = mk(`CEDC_VEC_UD);
                default:   next_st.rdata = 32'h00000000;
            endcase
        end

        // checks on the current instruction
        if (evt_in.valid) begin
            // descriptor load handling
            if (evt_in.desc_load) begin
                next_st.desc_bad = evt_in.acc_rights == `CEDC_DESC_BAD0 ||
                                   evt_in.acc_rights == `CEDC_DESC_BAD1;
                next_st.desc_rmw = !next_st.desc_bad &&
                                   !evt_in.desc_accessed;
            end
            // fault priority, decode faults first
            if (evt_in.lock_bad) begin
                next_st.flt = mk(`CEDC_VEC_UD);
            end else if (evt_in.insn_len > `CEDC_LEN_MAX) begin
                next_st.flt = mk(`CEDC_VEC_GP);
            end else if (evt_in.pte_walk && evt_in.pte_rsvd) begin
                next_st.flt = mk(`CEDC_VEC_PF);
            end else if (evt_in.mem_ref && evt_in.misalign &&
                         evt_in.align_chk) begin
                next_st.flt = mk(`CEDC_VEC_AC);
            end else if (evt_in.div_op && (evt_in.div_zero ||
                         div_ovf(evt_in.div_q, evt_in.div_word))) begin
                next_st.flt = mk(`CEDC_VEC_DE);
            end else if (evt_in.float_exc != 6'h00) begin
                next_st.flt = mk(`CEDC_VEC_XF);
            end else if (evt_in.hw_err && st.ecr[`CEDC_ECR_MCE]) begin
                next_st.flt = mk(`CEDC_VEC_MC);
            end
            // float conditions recorded, set beats clear
            next_st.pfcs[5:0] = next_st.pfcs[5:0] | evt_in.float_exc;
            // task switch flush and root load
            if (evt_in.task_sw) begin
                next_st.tlb_flush = 1'b1;
                if (!evt_in.tss16) begin
                    next_st.root = evt_in.new_root;
                end
            end
        end

        // breakpoint hits, sticky status, set beats clear
        next_st.bp_hit   = hit;
        next_st.bsr[3:0] = next_st.bsr[3:0] | hit;
    end

    // ---------------------------------------------
    // state register
    // ---------------------------------------------
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            st     <= '0;
            st.ecr <= `CEDC_ECR_RST;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    // outputs straight from state
    assign reg_rdata_out       = st.rdata;
    assign reg_flt_out         = st.reg_flt;
    assign flt_out             = st.flt;
    assign addr_hi_en_out      = st.addr_hi;
    assign pg_4m_out           = st.pg_4m;
    assign pg_2m_out           = st.pg_2m;
    assign tlb_flush_out       = st.tlb_flush;
    assign tlb_keep_global_out = st.keep_glob;
    assign desc_bad_out        = st.desc_bad;
    assign desc_rmw_out        = st.desc_rmw;
    assign bp_hit_out          = st.bp_hit;
    assign root_out            = st.root;

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    sequence s_bsr_set12;
        ce_in && reg_wr_in && reg_addr_in == `CEDC_OFS_BSR &&
        reg_wdata_in[`CEDC_BSR_RSV];
    endsequence

    sequence s_bsr_read;
        ce_in && reg_rd_in && reg_addr_in == `CEDC_OFS_BSR;
    endsequence

    sequence s_alias_acc;
        ce_in && (reg_wr_in || reg_rd_in) &&
        (reg_addr_in == `CEDC_OFS_ALA || reg_addr_in == `CEDC_OFS_ALB);
    endsequence

    chk_addr_ext_lines: assert property (
        (ce_in && st.ecr[`CEDC_ECR_PAE] && evt_in.paging && evt_in.prot_mode)
        |=> addr_hi_en_out)
        else $error("extra address lines not enabled");

    chk_real_mode_off: assert property (
        (ce_in && !evt_in.prot_mode) |=> !addr_hi_en_out && !pg_4m_out &&
        !pg_2m_out && !tlb_keep_global_out)
        else $error("paging feature active outside protected mode");

    chk_bsr_bit12: assert property (
        (s_bsr_set12 or s_bsr_read) |=>
        !st.bsr[`CEDC_BSR_RSV] && !reg_rdata_out[`CEDC_BSR_RSV])
        else $error("status bit 12 read back as one");

    chk_bcr_rsvd: assert property (
        (ce_in && reg_wr_in && reg_addr_in == `CEDC_OFS_BCR) |=>
        st.bcr[15:14] == 2'h0 && st.bcr[12:11] == 2'h0)
        else $error("control reserved bit set");

    chk_alias_ud: assert property (
        (s_alias_acc and ext_on) |=>
        reg_flt_out.v && reg_flt_out.vec == `CEDC_VEC_UD)
        else $error("alias slot access did not fault");

    chk_alias_map: assert property (
        (ce_in && reg_rd_in && !ext_on && reg_addr_in == `CEDC_OFS_ALB)
        |=> reg_rdata_out == $past(st.bcr) && !reg_flt_out.v)
        else $error("alias slot not mapped to control");

    chk_test_ud: assert property (
        (ce_in && (reg_wr_in || reg_rd_in) && reg_addr_in == `CEDC_OFS_TEST)
        |=> reg_flt_out.v && reg_flt_out.vec == `CEDC_VEC_UD)
        else $error("test register access did not fault");

    chk_hw_check_gate: assert property (
        (ce_in && evt_in.valid && evt_in.hw_err && !st.ecr[`CEDC_ECR_MCE])
        |=> !(flt_out.v && flt_out.vec == `CEDC_VEC_MC))
        else $error("hardware-error fault while disabled");

    chk_rsvd_write_gp: assert property (
        (ce_in && reg_wr_in && reg_addr_in == `CEDC_OFS_ECR &&
         (reg_wdata_in & ~`CEDC_ECR_MASK) != 32'h0)
        |=> reg_flt_out.vec == `CEDC_VEC_GP && $stable(st.ecr))
        else $error("reserved write not refused");

    chk_len_limit: assert property (
        (ce_in && evt_in.valid && !evt_in.lock_bad &&
         evt_in.insn_len > `CEDC_LEN_MAX)
        |=> flt_out.v && flt_out.vec == `CEDC_VEC_GP)
        else $error("overlong instruction not faulted");

    chk_root_tss16: assert property (
        (ce_in && evt_in.valid && evt_in.task_sw && evt_in.tss16 &&
         !(reg_wr_in && reg_addr_in == `CEDC_OFS_ROOT))
        |=> $stable(root_out) && tlb_flush_out)
        else $error("16-bit task switch changed root");

    chk_desc_rmw: assert property (
        (ce_in && evt_in.valid && evt_in.desc_load && evt_in.desc_accessed)
        |=> !desc_rmw_out)
        else $error("update on already accessed descriptor");

endmodule

`default_nettype wire

/* bench/cedc_core_test.sv */
`include "cedc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cedc_core_test;
    import cedc_pkg::*;
    logic        clock_in;
    logic        reset_in;
    logic [7:0]  reg_addr_in;
    logic [31:0] reg_wdata_in;
    logic        reg_wr_in;
    logic        reg_rd_in;
    cedc_evt_t   evt_in;
    logic [31:0] reg_rdata_out;
    cedc_flt_t   reg_flt_out;
    cedc_flt_t   flt_out;
    logic        addr_hi_en_out;
    logic        pg_4m_out;
    logic        pg_2m_out;
    logic        tlb_flush_out;
    logic        tlb_keep_global_out;
    logic        desc_bad_out;
    logic        desc_rmw_out;
    logic [3:0]  bp_hit_out;
    logic [31:0] root_out;
    int          err_count;
    int          n_tests;
    logic [31:0] seed;
    logic [31:0] rd_val;
    logic        fl;
    cedc_flt_t   rf;
    cedc_evt_t   idle;
    cedc_evt_t   e;

    // ---------------------------------------------
    // clock and device under test
    // ---------------------------------------------
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    cedc_core cedc_core_inst (
        .clock_in(clock_in), .reset_in(reset_in), .ce_in(1'b1),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .evt_in(evt_in),
        .reg_rdata_out(reg_rdata_out), .reg_flt_out(reg_flt_out), .flt_out(flt_out),
        .addr_hi_en_out(addr_hi_en_out), .pg_4m_out(pg_4m_out), .pg_2m_out(pg_2m_out),
        .tlb_flush_out(tlb_flush_out), .tlb_keep_global_out(tlb_keep_global_out),
        .desc_bad_out(desc_bad_out), .desc_rmw_out(desc_rmw_out),
        .bp_hit_out(bp_hit_out), .root_out(root_out)
    );

    // ---------------------------------------------
    // helpers
    // ---------------------------------------------
    // pseudo random source, fixed start
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // one register cycle, answer captured in the cycle after
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        reg_wr_in <= w;
        reg_rd_in <= !w;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        #1;
        rd_val = reg_rdata_out;
        rf = reg_flt_out;
    endtask

    // register fault outcome, vector only looked at when raised
    task automatic rchk(input logic fv, input logic [7:0] vec);
        chk("register fault", {23'h0, fv, vec}, {23'h0, rf.v, (rf.v === 1'b1) ? rf.vec : 8'h00});
    endtask

    // access and check the fault, and the data on reads
    task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic fv, input logic [7:0] vec);
        acc(w, a, d);
        if (!w) chk("read data", exp, rd_val);
        rchk(fv, vec);
    endtask

    // one instruction event, outputs captured in the cycle after
    task automatic ev(input cedc_evt_t x);
        @(posedge clock_in);
        evt_in <= x;
        @(posedge clock_in);
        evt_in <= idle;
        #1;
    endtask

    // instruction fault case: k selects the condition, q its argument
    task automatic fcase(input int k, input logic [31:0] q, input logic fv, input logic [7:0] vec);
        e = idle;
        e.valid = 1'b1;
        e.insn_len = 5'h01;
        case (k)
            0: e.lock_bad = 1'b1;
            1: e.insn_len = q[4:0];
            2: e.pte_rsvd = 1'b1;
            3: begin e.mem_ref = 1'b1; e.misalign = 1'b1; e.align_chk = q[0]; end
            4: begin e.div_op = 1'b1; e.div_q = q; end
            5: begin e.div_op = 1'b1; e.div_word = 1'b1; e.div_q = q; end
            6: begin e.div_op = 1'b1; e.div_zero = 1'b1; end
            7: e.float_exc = q[5:0];
            8: e.hw_err = 1'b1;
            default: begin e.lock_bad = 1'b1; e.insn_len = 5'h10; end
        endcase
        if (k == 2) e.pte_walk = 1'b1;
        ev(e);
        chk("fault", {23'h0, fv, vec}, {23'h0, flt_out.v, (flt_out.v === 1'b1) ? flt_out.vec : 8'h00});
        if (fv) chk("fault pointer", 32'h1, {31'h0, flt_out.cur});
    endtask

    // control flags against mode: lines, page sizes, global retention
    task automatic mchk(input logic [7:0] ev_ecr, input logic pm);
        rw(1'b1, `CEDC_OFS_ECR, {24'h0, ev_ecr}, 32'h0, 1'b0, 8'h00);
        idle.prot_mode = pm;
        idle.paging = 1'b1;
        @(posedge clock_in);
        evt_in <= idle;
        repeat (2) @(posedge clock_in);
        #1;
        chk("mode outputs", {28'h0, pm & ev_ecr[5], pm & ev_ecr[4] & !ev_ecr[5],
            pm & ev_ecr[4] & ev_ecr[5], pm & ev_ecr[7]},
            {28'h0, addr_hi_en_out, pg_4m_out, pg_2m_out, tlb_keep_global_out});
    endtask

    // descriptor load outcome {invalid, locked update}
    task automatic dchk(input logic [7:0] rights, input logic accd, input logic [1:0] exp);
        e = idle;
        e.valid = 1'b1;
        e.desc_load = 1'b1;
        e.acc_rights = rights;
        e.desc_accessed = accd;
        ev(e);
        chk("descriptor", {30'h0, exp}, {30'h0, desc_bad_out, desc_rmw_out});
    endtask

    // root change through task switch, flush looked for over two cycles
    task automatic tchk(input logic t16, input logic [31:0] nr, input logic [31:0] exp);
        e = idle;
        e.valid = 1'b1;
        e.task_sw = 1'b1;
        e.tss16 = t16;
        e.new_root = nr;
        ev(e);
        fl = tlb_flush_out;
        @(posedge clock_in);
        #1;
        fl = fl | tlb_flush_out;
        chk("root", exp, root_out);
        chk("task switch flush", 32'h1, {31'h0, fl});
    endtask

    task automatic complete_run;
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        reset_in = 1'b1;
        reg_addr_in = 8'h00;
        reg_wdata_in = 32'h0;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        idle = '0;
        evt_in = '0;
        err_count = 0;
        n_tests = 0;
        seed = 32'd95598;
        repeat (2) @(posedge clock_in);
        reset_in <= 1'b0;
        rw(1'b0, `CEDC_OFS_ECR, 32'h0, `CEDC_ECR_RST, 1'b0, 8'h00);
        for (int i = 0; i < 16; i++) begin
            mchk({i[3], 1'b0, i[1:0], 4'h0}, i[2]);
        end
        seed = lfsr(seed) | 32'h1;
        rw(1'b1, `CEDC_OFS_ECR, seed, 32'h0, 1'b1, `CEDC_VEC_GP);
        rw(1'b0, `CEDC_OFS_ECR, 32'h0, 32'h000000b0, 1'b0, 8'h00);
        rw(1'b1, `CEDC_OFS_PFCS, 32'h00010000, 32'h0, 1'b1, `CEDC_VEC_GP);
        rw(1'b1, `CEDC_OFS_ECR, 32'h0, 32'h0, 1'b0, 8'h00);
        rw(1'b1, `CEDC_OFS_BSR, 32'hffffffff, 32'h0, 1'b0, 8'h00);
        rw(1'b0, `CEDC_OFS_BSR, 32'h0, `CEDC_BSR_MASK, 1'b0, 8'h00);
        rw(1'b0, `CEDC_OFS_ALA, 32'h0, `CEDC_BSR_MASK, 1'b0, 8'h00);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            rw(1'b1, (i[0] ? `CEDC_OFS_ALB : `CEDC_OFS_BCR), seed, 32'h0, 1'b0, 8'h00);
            rw(1'b0, `CEDC_OFS_BCR, 32'h0, seed & `CEDC_BCR_MASK, 1'b0, 8'h00);
            rw(1'b0, `CEDC_OFS_ALB, 32'h0, seed & `CEDC_BCR_MASK, 1'b0, 8'h00);
        end
        for (int d = 0; d < 2; d++) begin
            rw(1'b1, `CEDC_OFS_ECR, {28'h0, d[0], 3'b000}, 32'h0, 1'b0, 8'h00);
            rw(1'b0, `CEDC_OFS_TEST, 32'h0, 32'h0, 1'b1, `CEDC_VEC_UD);
            rw(1'b1, `CEDC_OFS_TEST, seed, 32'h0, 1'b1, `CEDC_VEC_UD);
        end
        rw(1'b0, `CEDC_OFS_ALA, 32'h0, 32'h0, 1'b1, `CEDC_VEC_UD);
        rw(1'b1, `CEDC_OFS_ALB, 32'h0, 32'h0, 1'b1, `CEDC_VEC_UD);
        rw(1'b0, `CEDC_OFS_BCR, 32'h0, seed & `CEDC_BCR_MASK, 1'b0, 8'h00);
        rw(1'b1, `CEDC_OFS_BCR, 32'h321000ff, 32'h0, 1'b0, 8'h00);
        for (int d = 0; d < 2; d++) begin
            rw(1'b1, `CEDC_OFS_ECR, {28'h0, d[0], 3'b000}, 32'h0, 1'b0, 8'h00);
            for (int k = 0; k < 4; k++) begin
                e = idle;
                e.valid = 1'b1;
                e.acc_valid = 1'b1;
                e.acc_kind = cedc_acc_t'(k);
                ev(e);
                chk("breakpoint hits", {28'h0, k == 1 || k == 2, k == 3 && d == 1, k == 1, k == 0},
                    {28'h0, bp_hit_out});
            end
        end
        rw(1'b1, `CEDC_OFS_ECR, 32'h0, 32'h0, 1'b0, 8'h00);
        rw(1'b1, `CEDC_OFS_PFCS, 32'h0, 32'h0, 1'b0, 8'h00);
        fcase(0, 0, 1'b1, `CEDC_VEC_UD);
        fcase(9, 0, 1'b1, `CEDC_VEC_UD);
        fcase(1, 32'h10, 1'b1, `CEDC_VEC_GP);
        fcase(1, 32'h0f, 1'b0, 8'h00);
        fcase(2, 0, 1'b1, `CEDC_VEC_PF);
        fcase(3, 1, 1'b1, `CEDC_VEC_AC);
        fcase(3, 0, 1'b0, 8'h00);
        fcase(4, -32'sd128, 1'b0, 8'h00);
        fcase(4, 32'd128, 1'b1, `CEDC_VEC_DE);
        fcase(5, -32'sd32768, 1'b0, 8'h00);
        fcase(5, 32'd32768, 1'b1, `CEDC_VEC_DE);
        fcase(6, 0, 1'b1, `CEDC_VEC_DE);
        fcase(8, 0, 1'b0, 8'h00);
        fcase(7, 32'h05, 1'b1, `CEDC_VEC_XF);
        rw(1'b0, `CEDC_OFS_PFCS, 32'h0, 32'h05, 1'b0, 8'h00);
        rw(1'b1, `CEDC_OFS_ECR, 32'h40, 32'h0, 1'b0, 8'h00);
        fcase(8, 0, 1'b1, `CEDC_VEC_MC);
        dchk(`CEDC_DESC_BAD0, 1'b0, 2'b10);
        dchk(`CEDC_DESC_BAD1, 1'b0, 2'b10);
        dchk(8'h93, 1'b0, 2'b01);
        dchk(8'h93, 1'b1, 2'b00);
        rw(1'b1, `CEDC_OFS_ROOT, 32'h00aab000, 32'h0, 1'b0, 8'h00);
        fl = tlb_flush_out;
        @(posedge clock_in);
        #1;
        chk("root write flush", 32'h1, {31'h0, fl | tlb_flush_out});
        chk("root", 32'h00aab000, root_out);
        tchk(1'b1, 32'h00123000, 32'h00aab000);
        tchk(1'b0, 32'h00123000, 32'h00123000);
        complete_run;
    end

    // hang guard, well beyond the expected run length
    initial begin
        #100000;
        err_count++;
        complete_run;
    end
endmodule

`default_nettype wire
